// ### design/epci_pkg.sv
// Package for the external and pin-change interrupt block
`default_nettype none
package epci_pkg;
    // Register byte offsets on APB
    localparam logic [11:0] OFF_ENABLE_CTRL = 12'h000;
    localparam logic [11:0] OFF_PENDING     = 12'h004;
    localparam logic [11:0] OFF_MASK_HI     = 12'h008;
    localparam logic [11:0] OFF_MASK_LO     = 12'h00C;
    localparam logic [11:0] OFF_SENSE_CTRL  = 12'h010;
    localparam logic [11:0] OFF_CORE_CTRL   = 12'h014;
    localparam logic [11:0] OFF_PIN_STATE   = 12'h018;

    // Enable and pending bit positions
    localparam int BIT_EXT_B = 7;
    localparam int BIT_EXT_A = 6;
    localparam int BIT_EXT_C = 5;
    localparam int BIT_PC_HI = 4;
    localparam int BIT_PC_LO = 3;

    // Sense control layout: [3:2] ext_b, [1:0] ext_a, [4] ext_c edge select
    localparam int SENSE_B_LSB = 2;
    localparam int SENSE_A_LSB = 0;
    localparam int SENSE_C_BIT = 4;

    // Core control bits: [0] global enable, [1] legacy mode, [2] sleep buffer off
    localparam int CORE_GIE_BIT    = 0;
    localparam int CORE_LEGACY_BIT = 1;
    localparam int CORE_SLEEP_BIT  = 2;

    // Reset values
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_MASK   = 8'h00;
    localparam logic [7:0] RST_SENSE  = 8'h00;
    localparam logic [7:0] RST_CORE   = 8'h00;
    localparam logic [7:0] RST_FLAGS  = 8'h00;

    // Sense encodings for ext_a and ext_b
    localparam logic [1:0] SENSE_LOW  = 2'h0;
    localparam logic [1:0] SENSE_ANY  = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;

    // Vector request / acknowledge bundle toward the core
    typedef struct packed {
        logic ext_b;
        logic ext_a;
        logic ext_c;
        logic pc_hi;
        logic pc_lo;
    } epci_vec_t;

    // Bus access state
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACCESS = 2'b10
    } epci_state_t;
endpackage
`default_nettype wire

// ### design/epci_top.sv
// External and pin-change interrupt controller with APB registers
// What this block does
// - High group enabled by its bit and global
// - Unmasked upper pin change raises high request
// - Low group enabled by its bit and global
// - Unmasked lower pin change raises low request
// - Ext B trigger sets pending bit 7
// - Ext A trigger sets pending bit 6
// - Ext C trigger sets pending bit 5
// - Upper pin change sets pending bit 4
// - Lower pin change sets pending bit 3
// - Pending, enabled and global give vector request
// - Taking the vector clears its flag
// - Writing one clears flag, zero keeps it
// - Ext B low-level mode keeps flag clear
// - Ext A low-level mode keeps flag clear
// - Sleep buffer-off may set ext C flag
// - High mask bits gate upper pins
// - Low mask bits gate lower pins
// - Legacy mode disables pin-change interrupts
// - Two-bit sense: low, any, fall, rise
// - Ext C edges caught asynchronously, edge selectable
// - Enable bits 7,6,5 for B,A,C; pins watched even when disabled, except C with sleep buffer off
// - Pulses over one clock are detected
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
module epci_top (
    // APB clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // External pins
    input  wire logic                ext_irq_a,
    input  wire logic                ext_irq_b,
    input  wire logic                ext_irq_c,
    input  wire logic [7:0]          pc_pins_hi,
    input  wire logic [7:0]          pc_pins_lo,
    // Core side
    input  wire epci_pkg::epci_vec_t vec_taken,
    output epci_pkg::epci_vec_t      vec_request,
    output logic                     ext_a_level_req,
    output logic                     ext_b_level_req
);
    // Registers
    logic [7:0] enable_reg;
    logic [7:0] mask_hi_reg;
    logic [7:0] mask_lo_reg;
    logic [7:0] sense_reg;
    logic [7:0] core_reg;
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    epci_pkg::epci_state_t state_reg;

    // Two-stage synchronisers; stage one read only by stage two
    logic [17:0] sync1_reg;
    logic [17:0] sync2_reg;
    logic [17:0] prev_reg;
    wire  [17:0] pins_raw = {ext_irq_b, ext_irq_a, pc_pins_hi, pc_pins_lo};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 18'h0_0000;
            sync2_reg <= 18'h0_0000;
            prev_reg  <= 18'h0_0000;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    wire [17:0] changed = sync2_reg ^ prev_reg;
    wire        a_now   = sync2_reg[16];
    wire        a_prev  = prev_reg[16];
    wire        b_now   = sync2_reg[17];
    wire        b_prev  = prev_reg[17];

    // Asynchronous edge catcher for ext C. The pin clocks a flop; the
    // toggle it makes is synchronised and edge-detected in pclk.
    wire ext_c_edge_sel  = sense_reg[epci_pkg::SENSE_C_BIT];
    wire ext_c_buf_off   = core_reg[epci_pkg::CORE_SLEEP_BIT]
                           & ~enable_reg[epci_pkg::BIT_EXT_C];
    wire ext_c_internal  = ext_irq_c & ~ext_c_buf_off;
    // polarity via xor, rising edge on clock pin
    wire ext_c_clk       = ext_c_internal ^ ~ext_c_edge_sel;
    logic c_tog_reg;
    logic [2:0] c_sync_reg;

    always_ff @(posedge ext_c_clk or negedge presetn) begin
        if (!presetn) begin
            c_tog_reg <= 1'b0;
        end else begin
            c_tog_reg <= ~c_tog_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_sync_reg <= 3'h0;
        end else begin
            c_sync_reg <= {c_sync_reg[1:0], c_tog_reg};
        end
    end

    wire ext_c_event = c_sync_reg[2] ^ c_sync_reg[1];

    // Sense decoding for ext A and B
    wire [1:0] sense_a = sense_reg[epci_pkg::SENSE_A_LSB +: 2];
    wire [1:0] sense_b = sense_reg[epci_pkg::SENSE_B_LSB +: 2];
    wire       a_level = (sense_a == epci_pkg::SENSE_LOW);
    wire       b_level = (sense_b == epci_pkg::SENSE_LOW);

    wire a_trig = (sense_a == epci_pkg::SENSE_ANY  && (a_now ^ a_prev))
               || (sense_a == epci_pkg::SENSE_FALL && !a_now && a_prev)
               || (sense_a == epci_pkg::SENSE_RISE && a_now && !a_prev);
    wire b_trig = (sense_b == epci_pkg::SENSE_ANY  && (b_now ^ b_prev))
               || (sense_b == epci_pkg::SENSE_FALL && !b_now && b_prev)
               || (sense_b == epci_pkg::SENSE_RISE && b_now && !b_prev);

    wire legacy = core_reg[epci_pkg::CORE_LEGACY_BIT];
    wire pc_hi_trig = |(changed[15:8] & mask_hi_reg) & ~legacy;
    wire pc_lo_trig = |(changed[7:0] & mask_lo_reg) & ~legacy;

    // APB decode
    wire setup_wr   = psel && !penable && pwrite && (state_reg == epci_pkg::ST_IDLE);
    wire acc_done   = psel && penable && (state_reg == epci_pkg::ST_ACCESS);
    wire wr_en      = acc_done && pwrite && pstrb[0];
    wire hit_enable = paddr == epci_pkg::OFF_ENABLE_CTRL;
    wire hit_pend   = paddr == epci_pkg::OFF_PENDING;
    wire hit_mhi    = paddr == epci_pkg::OFF_MASK_HI;
    wire hit_mlo    = paddr == epci_pkg::OFF_MASK_LO;
    wire hit_sense  = paddr == epci_pkg::OFF_SENSE_CTRL;
    wire hit_core   = paddr == epci_pkg::OFF_CORE_CTRL;
    wire hit_pins   = paddr == epci_pkg::OFF_PIN_STATE;
    wire hit_any    = hit_enable | hit_pend | hit_mhi | hit_mlo
                    | hit_sense | hit_core | hit_pins;
    wire [7:0] wbyte = pwdata[7:0];

    wire [7:0] sw_clear = (wr_en && hit_pend) ? wbyte : 8'h00;
    wire [7:0] hw_clear = {vec_taken.ext_b, vec_taken.ext_a, vec_taken.ext_c,
                           vec_taken.pc_hi, vec_taken.pc_lo, 3'h0};
    wire [7:0] hw_set   = {b_trig, a_trig, ext_c_event, pc_hi_trig, pc_lo_trig, 3'h0};
    wire [7:0] force_clr = {b_level, a_level, 6'h00};

    // Set wins over a same-cycle clear
    assign flags_next = ((flags_reg & ~(sw_clear | hw_clear)) | hw_set) & ~force_clr;

    wire gie = core_reg[epci_pkg::CORE_GIE_BIT];

    wire [7:0] armed = enable_reg & {8{gie}} & 8'hF8;

    wire [7:0] req_bits = flags_reg & armed;

    logic [7:0] rdata_byte;
    always_comb begin
        rdata_byte = 8'h00;
        if (hit_enable) rdata_byte = enable_reg;
        if (hit_pend)   rdata_byte = flags_reg;
        if (hit_mhi)    rdata_byte = mask_hi_reg;
        if (hit_mlo)    rdata_byte = mask_lo_reg;
        if (hit_sense)  rdata_byte = sense_reg;
        if (hit_core)   rdata_byte = core_reg;
        if (hit_pins)   rdata_byte = {b_now, a_now, 6'h00};
    end

    // Registers and flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg  <= epci_pkg::RST_ENABLE;
            mask_hi_reg <= epci_pkg::RST_MASK;
            mask_lo_reg <= epci_pkg::RST_MASK;
            sense_reg   <= epci_pkg::RST_SENSE;
            core_reg    <= epci_pkg::RST_CORE;
            flags_reg   <= epci_pkg::RST_FLAGS;
        end else begin
            flags_reg <= flags_next;
            if (wr_en && hit_enable) enable_reg  <= wbyte & 8'hF8;
            if (wr_en && hit_mhi)    mask_hi_reg <= wbyte;
            if (wr_en && hit_mlo)    mask_lo_reg <= wbyte;
            if (wr_en && hit_sense)  sense_reg   <= wbyte & 8'h1F;
            if (wr_en && hit_core)   core_reg    <= wbyte & 8'h07;
        end
    end

    // Bus state and registered outputs; answer one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg       <= epci_pkg::ST_IDLE;
            pready          <= 1'b0;
            pslverr         <= 1'b0;
            prdata          <= 32'h0000_0000;
            vec_request     <= '0;
            ext_a_level_req <= 1'b0;
            ext_b_level_req <= 1'b0;
        end else begin
            case (state_reg)
                epci_pkg::ST_IDLE: begin
                    pready <= 1'b0;
                    if (psel && !penable) begin
                        state_reg <= epci_pkg::ST_ACCESS;
                        pready    <= 1'b1;
                        pslverr   <= !hit_any || (setup_wr && hit_pins);
                        prdata    <= {24'h00_0000, rdata_byte};
                    end
                end
                epci_pkg::ST_ACCESS: begin
                    pready    <= 1'b0;
                    pslverr   <= 1'b0;
                    state_reg <= epci_pkg::ST_IDLE;
                end
                default: state_reg <= epci_pkg::ST_IDLE;
            endcase
            vec_request <= '{ext_b: req_bits[epci_pkg::BIT_EXT_B],
                             ext_a: req_bits[epci_pkg::BIT_EXT_A],
                             ext_c: req_bits[epci_pkg::BIT_EXT_C],
                             pc_hi: req_bits[epci_pkg::BIT_PC_HI],
                             pc_lo: req_bits[epci_pkg::BIT_PC_LO]};
            // Low-level sense requests directly while pin is low
            ext_a_level_req <= a_level && !a_now && armed[epci_pkg::BIT_EXT_A];
            ext_b_level_req <= b_level && !b_now && armed[epci_pkg::BIT_EXT_B];
        end
    end
endmodule
`default_nettype wire

// ### tb/epci_pins.sv
// Pin-side model driving the external and pin-change lines
`default_nettype none
module epci_pins (
    // Clock
    input  wire logic  pclk,
    // Lines: a, b, c, upper group, lower group
    output logic [18:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pins = 19'h7_0000;
    // levels held far beyond one clock
    task automatic drive(input logic [18:0] v);
        pins <= v;
        repeat (6) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ### tb/epci_properties.sv
// Port-level checks for the interrupt controller
`default_nettype none
module epci_properties (
    // Clock, reset and bus
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [3:0]          pstrb,
    input wire logic                pready,
    // Core side
    input wire epci_pkg::epci_vec_t vec_taken,
    input wire epci_pkg::epci_vec_t vec_request,
    input wire logic                ext_a_level_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadows follow the same write edge as the design
    logic [7:0] en_q;
    logic [7:0] core_q;
    logic [7:0] sense_q;
    wire logic  wr = psel && penable && pwrite && pready && pstrb[0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 8'h00;
            core_q <= 8'h00;
            sense_q <= 8'h00;
        end else begin
            en_q <= (wr && paddr == epci_pkg::OFF_ENABLE_CTRL) ? pwdata[7:0] : en_q;
            core_q <= (wr && paddr == epci_pkg::OFF_CORE_CTRL) ? pwdata[7:0] : core_q;
            sense_q <= (wr && paddr == epci_pkg::OFF_SENSE_CTRL) ? pwdata[7:0] : sense_q;
        end
    end
    a_taken_drops_hi: assert property (vec_taken.pc_hi |-> ##2 !vec_request.pc_hi)
        else $error("upper group request held after taken");
    a_write_one_clears: assert property (
        wr && paddr == epci_pkg::OFF_PENDING && pwdata[3] |-> ##2 !vec_request.pc_lo)
        else $error("lower group request held after clear");
    a_global_gate: assert property (!core_q[0] |=> vec_request == '0)
        else $error("request without global enable");
    a_hi_group_gate: assert property (!en_q[4] |=> !vec_request.pc_hi)
        else $error("upper group request while disabled");
    a_lo_req_cause: assert property (vec_request.pc_lo |-> $past(core_q[0] && en_q[3]))
        else $error("lower group request without enables");
    a_low_a_clear: assert property ((sense_q[1:0] == 2'h0) [*3] |-> !vec_request.ext_a)
        else $error("line a request in level mode");
    a_low_b_clear: assert property ((sense_q[3:2] == 2'h0) [*3] |-> !vec_request.ext_b)
        else $error("line b request in level mode");
    a_level_req_mode: assert property (
        ext_a_level_req |-> $past(sense_q[1:0] == 2'h0 && en_q[6]))
        else $error("level request outside level mode");
    c_lo_request: cover property (vec_request.pc_lo);
    c_level_req: cover property (ext_a_level_req);
    c_taken_hi: cover property (vec_taken.pc_hi);
endmodule
bind epci_top epci_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .vec_taken(vec_taken),
    .vec_request(vec_request), .ext_a_level_req(ext_a_level_req)
);
`default_nettype wire

// ### tb/testbench.sv
// Directed bench for the interrupt controller
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] EN = epci_pkg::OFF_ENABLE_CTRL;
    localparam logic [11:0] PF = epci_pkg::OFF_PENDING;
    localparam logic [11:0] SC = epci_pkg::OFF_SENSE_CTRL;
    localparam logic [11:0] CC = epci_pkg::OFF_CORE_CTRL;
    logic                pclk = 1'b0, presetn = 1'b0;
    logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]         paddr = 12'h000;
    logic [31:0]         pwdata = 32'h0000_0000, prdata, rdata;
    logic                pready, pslverr, err, lvl_a, lvl_b;
    wire logic [18:0]    pin;
    epci_pkg::epci_vec_t vec_taken = '0, vec_request;
    int                  n_mismatch = 0, checked = 0;
    epci_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq_a(pin[18]), .ext_irq_b(pin[17]), .ext_irq_c(pin[16]),
        .pc_pins_hi(pin[15:8]), .pc_pins_lo(pin[7:0]), .vec_taken(vec_taken),
        .vec_request(vec_request), .ext_a_level_req(lvl_a), .ext_b_level_req(lvl_b)
    );
    epci_pins pm (.pclk(pclk), .pins(pin));
    always #25 pclk = ~pclk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Check flags and requests, then clear every flag
    task automatic flags(input logic [7:0] ef, input logic [4:0] er);
        apb(1'b0, PF, 8'h00);
        chk("pending", {24'h00_0000, ef}, rdata);
        chk("request", {27'h000_0000, er}, {27'h000_0000, vec_request});
        apb(1'b1, PF, 8'hF8);
    endtask
    task automatic tog(input logic [18:0] m);
        pm.drive(pm.pins ^ m);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #1ms;
        n_mismatch++;
        stop_test;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'(4 * i), 8'h00);
            chk("reset value", 32'h0000_0000, rdata);
        end
        apb(1'b1, epci_pkg::OFF_PIN_STATE, 8'hFF);
        chk("read-only error", 32'h0000_0001, {31'h0000_0000, err});
        apb(1'b0, 12'h01C, 8'h00);
        chk("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
        $display("register test finished");
        apb(1'b1, EN, 8'hF8);
        apb(1'b1, CC, 8'h01);
        apb(1'b1, SC, 8'h05);
        apb(1'b1, epci_pkg::OFF_MASK_LO, 8'h01);
        apb(1'b1, epci_pkg::OFF_MASK_HI, 8'h80);
        tog(19'h0_0002);
        flags(8'h00, 5'h00);
        tog(19'h0_0001);
        apb(1'b1, PF, 8'h00);
        flags(8'h08, 5'h01);
        flags(8'h00, 5'h00);
        tog(19'h0_4000);
        flags(8'h00, 5'h00);
        tog(19'h0_8000);
        flags(8'h10, 5'h02);
        tog(19'h0_8000);
        vec_taken.pc_hi <= 1'b1;
        @(posedge pclk);
        vec_taken <= '0;
        flags(8'h00, 5'h00);
        apb(1'b1, EN, 8'hF0);
        tog(19'h0_0001);
        flags(8'h08, 5'h00);
        apb(1'b1, CC, 8'h03);
        tog(19'h0_0001);
        flags(8'h00, 5'h00);
        apb(1'b1, CC, 8'h01);
        apb(1'b1, EN, 8'hF8);
        $display("pin change test finished");
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, SC, 8'(5 * m));
            tog(19'h6_0000);
            flags((m != 3) ? 8'hC0 : 8'h00, (m != 3) ? 5'h18 : 5'h00);
            tog(19'h6_0000);
            flags((m != 2) ? 8'hC0 : 8'h00, (m != 2) ? 5'h18 : 5'h00);
        end
        apb(1'b1, SC, 8'h00);
        tog(19'h6_0000);
        flags(8'h00, 5'h00);
        chk("level requests", 32'h0000_0003, {30'h0000_0000, lvl_a, lvl_b});
        tog(19'h6_0000);
        $display("external line test finished");
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, SC, 8'(16 * s + 5));
            apb(1'b1, PF, 8'hF8);
            tog(19'h1_0000);
            flags(8'h20, 5'h04);
        end
        // Line c disabled, buffer off: internal low makes a falling edge
        apb(1'b1, SC, 8'h05);
        apb(1'b1, EN, 8'hD8);
        apb(1'b1, CC, 8'h05);
        tog(19'h0_0000);
        flags(8'h20, 5'h00);
        apb(1'b1, CC, 8'h01);
        $display("edge line test finished");
        stop_test;
    end
endmodule
`default_nettype wire
